/* File: core/tiof_pkg.sv */
// Package for the trigger, pin-supply and frame-info register bank.
// Assumes: 32-bit AXI4-Lite register access, one clock domain.
package tiof_pkg;
    // Register byte addresses
    localparam logic [15:0] TIOF_TRIG_CTRL_OFF   = 16'h0830;
    localparam logic [15:0] TIOF_FRAME_INFO_OFF  = 16'h12F8;
    localparam logic [15:0] TIOF_SUPPLY_EN_OFF   = 16'h19D0;
    localparam logic [15:0] TIOF_PIN_STATUS_OFF  = 16'h19D4;
    // Field positions, MSB-first numbering converted to little-endian bit index (31 - pos)
    localparam int TIOF_PRESENCE_BIT   = 31;
    localparam int TIOF_ABS_CTRL_BIT   = 30;
    localparam int TIOF_ON_OFF_BIT     = 25;
    localparam int TIOF_POLARITY_BIT   = 24;
    localparam int TIOF_SOURCE_LSB     = 21;
    localparam int TIOF_TRIG_VALUE_BIT = 20;
    localparam int TIOF_MODE_LSB       = 16;
    localparam int TIOF_PARAM_LSB      = 0;
    localparam int TIOF_SUPPLY_BIT     = 0;
    localparam int TIOF_AVAIL_LSB      = 16;
    localparam int TIOF_VALFMT_BIT     = 15;
    // Reset values
    localparam logic       TIOF_SUPPLY_RST   = 1'b0;
    localparam logic       TIOF_ON_OFF_RST   = 1'b0;
    localparam logic       TIOF_ABS_RST      = 1'b0;
    localparam logic       TIOF_POL_RST      = 1'b0;
    localparam logic [2:0] TIOF_SOURCE_RST   = 3'h0;
    localparam logic [3:0] TIOF_MODE_RST     = 4'h0;
    localparam logic [11:0] TIOF_PARAM_RST   = 12'h000;
    // AXI responses
    localparam logic [1:0] TIOF_RESP_OKAY    = 2'h0;
    localparam logic [1:0] TIOF_RESP_SLVERR  = 2'h2;
endpackage : tiof_pkg

/* File: core/tiof_trig_sel.sv */
// Trigger pin selector: synchronises the pins and picks the chosen one.
// Assumes: pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tiof_trig_sel #(
    parameter int NPINS = 8
) (
    input  wire logic             clk,      // System clock
    input  wire logic             srst,     // Sync reset
    input  wire logic [NPINS-1:0] pins_in,  // Raw pin levels
    input  wire logic [2:0]       sel,      // Chosen pin
    input  wire logic             pol_high, // Active-high polarity
    output logic                  raw_q,    // Synced raw level
    output logic                  active_q  // Polarity-adjusted level
);
    logic [NPINS-1:0] s1_q;
    logic [NPINS-1:0] s2_q;
    // Elaboration check: a three-bit select reaches at most eight pins
    if (NPINS < 1 || NPINS > 8) begin : g_bad_npins
        $error("NPINS must be 1..8");
    end
    // Two-stage synchroniser per pin
    genvar g;
    for (g = 0; g < NPINS; g++) begin : g_sync
        always_ff @(posedge clk) begin
            if (srst) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
            end else begin
                s1_q[g] <= pins_in[g];
                s2_q[g] <= s1_q[g];
            end
        end
    end
    // Selected level and active level
    always_ff @(posedge clk) begin
        if (srst) begin
            raw_q    <= 1'b0;
            active_q <= 1'b0;
        end else begin
            raw_q    <= (int'(sel) < NPINS) ? s2_q[sel] : 1'b0;
            active_q <= ((int'(sel) < NPINS) ? s2_q[sel] : 1'b0) ~^ pol_high;
        end
    end
endmodule : tiof_trig_sel
`default_nettype wire

/* File: core/tiof_regs.sv */
// Register bank: pin supply enable, trigger control, frame-info capabilities.
// Assumes: AXI4-Lite master with one read and one write outstanding.
//
// Function
// - Supply-enable bit switches 3.3 V on the pin; resets off.
// - Top bit of each register except pin status reads presence; it is not writable.
// - With absolute control set, the parameter field is read-only.
// - On/off bit reads status; when off, other trigger fields ignore writes.
// - Polarity bit: zero active low, one active high; not software trigger.
// - Three-bit source field picks the trigger input pin.
// - Trigger value bit reads the raw selected pin level; writes ignored.
// - Four-bit mode field selects one of sixteen trigger modes.
// - Twelve-bit parameter field holds the mode argument.
// - Frame-info register shows ten read-only item capability bits.
// - Value-format bit reads relative or absolute; currently read-only.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tiof_regs
    import tiof_pkg::*;
#(
    parameter int         NPINS       = 8,
    parameter logic [9:0] AVAIL_ITEMS = 10'h3FF,
    parameter logic       ABS_FMT     = 1'b0
) (
    input  wire logic             clk,           // System clock
    input  wire logic             srst,          // Sync reset
    input  wire logic [15:0]      s_axi_awaddr,  // Write address
    input  wire logic             s_axi_awvalid, // Write address valid
    output logic                  s_axi_awready, // Write address ready
    input  wire logic [31:0]      s_axi_wdata,   // Write data
    input  wire logic [3:0]       s_axi_wstrb,   // Byte strobes
    input  wire logic             s_axi_wvalid,  // Write data valid
    output logic                  s_axi_wready,  // Write data ready
    output logic [1:0]            s_axi_bresp,   // Write response
    output logic                  s_axi_bvalid,  // Write response valid
    input  wire logic             s_axi_bready,  // Write response ready
    input  wire logic [15:0]      s_axi_araddr,  // Read address
    input  wire logic             s_axi_arvalid, // Read address valid
    output logic                  s_axi_arready, // Read address ready
    output logic [31:0]           s_axi_rdata,   // Read data
    output logic [1:0]            s_axi_rresp,   // Read response
    output logic                  s_axi_rvalid,  // Read data valid
    input  wire logic             s_axi_rready,  // Read data ready
    input  wire logic [NPINS-1:0] gpio_in,       // Raw pin levels
    output logic                  supply_en,     // 3.3 V output enable
    output logic                  trig_enable,   // Trigger feature on
    output logic [2:0]            trig_source,   // Selected pin
    output logic [3:0]            trig_mode,     // Trigger mode
    output logic [11:0]           trig_param,    // Mode parameter
    output logic                  trig_abs,      // Absolute control
    output logic                  trig_active    // Polarity-adjusted trigger level
);
    import tiof_pkg::*;

    logic        supply_q;
    logic        on_q;
    logic        abs_q;
    logic        pol_q;
    logic [2:0]  src_q;
    logic [3:0]  mode_q;
    logic [11:0] param_q;
    logic        raw_lvl;
    logic        act_lvl;
    logic        aw_q;
    logic [15:0] awaddr_q;
    logic        w_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        do_wr;
    logic [31:0] wbits;
    logic        wr_hit;
    logic [31:0] rd_val;
    logic        rd_hit;

    // Elaboration check: the source field reaches at most eight pins
    if (NPINS < 1 || NPINS > 8) begin : g_bad_npins
        $error("NPINS must be 1..8");
    end

    // Pin synchroniser and selection
    tiof_trig_sel #(.NPINS(NPINS)) u_sel (
        .clk      (clk),
        .srst     (srst),
        .pins_in  (gpio_in),
        .sel      (src_q),
        .pol_high (pol_q),
        .raw_q    (raw_lvl),
        .active_q (act_lvl)
    );

    // Address and data capture, either order
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 16'h0000;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q  <= 1'b0;
            end
        end
    end

    // Write commits once both halves are held
    assign do_wr = aw_q && w_q && !s_axi_bvalid;
    always_comb begin
        wbits = wdata_q;
        for (int b = 0; b < 4; b++) begin
            if (!wstrb_q[b]) wbits[b*8 +: 8] = 8'h00;
        end
    end
    assign wr_hit = ({awaddr_q[15:2], 2'b00} == TIOF_SUPPLY_EN_OFF) ||
                    ({awaddr_q[15:2], 2'b00} == TIOF_TRIG_CTRL_OFF) ||
                    ({awaddr_q[15:2], 2'b00} == TIOF_FRAME_INFO_OFF) ||
                    ({awaddr_q[15:2], 2'b00} == TIOF_PIN_STATUS_OFF);

    // Write response
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= TIOF_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? TIOF_RESP_OKAY : TIOF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Supply enable bit
    always_ff @(posedge clk) begin
        if (srst) begin
            supply_q <= TIOF_SUPPLY_RST;
        end else if (do_wr && {awaddr_q[15:2], 2'b00} == TIOF_SUPPLY_EN_OFF && wstrb_q[0]) begin
            supply_q <= wbits[TIOF_SUPPLY_BIT];
        end
    end

    // Trigger control fields; only on/off is writable while off
    always_ff @(posedge clk) begin
        if (srst) begin
            on_q    <= TIOF_ON_OFF_RST;
            abs_q   <= TIOF_ABS_RST;
            pol_q   <= TIOF_POL_RST;
            src_q   <= TIOF_SOURCE_RST;
            mode_q  <= TIOF_MODE_RST;
            param_q <= TIOF_PARAM_RST;
        end else if (do_wr && {awaddr_q[15:2], 2'b00} == TIOF_TRIG_CTRL_OFF) begin
            if (wstrb_q[3]) on_q <= wbits[TIOF_ON_OFF_BIT];
            if (on_q) begin
                if (wstrb_q[3]) begin
                    abs_q <= wbits[TIOF_ABS_CTRL_BIT];
                    pol_q <= wbits[TIOF_POLARITY_BIT];
                end
                if (wstrb_q[2]) begin
                    src_q  <= wbits[TIOF_SOURCE_LSB +: 3];
                    mode_q <= wbits[TIOF_MODE_LSB +: 4];
                end
                if (!abs_q) begin
                    if (wstrb_q[0]) param_q[7:0] <= wbits[TIOF_PARAM_LSB +: 8];
                    if (wstrb_q[1]) param_q[11:8] <= wbits[TIOF_PARAM_LSB+8 +: 4];
                end
            end
        end
    end

    // Read mux; reserved bits zero, presence fixed one except in pin status
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[15:2], 2'b00})
            TIOF_SUPPLY_EN_OFF: begin
                rd_val[TIOF_PRESENCE_BIT] = 1'b1;
                rd_val[TIOF_SUPPLY_BIT]   = supply_q;
            end
            TIOF_TRIG_CTRL_OFF: begin
                rd_val[TIOF_PRESENCE_BIT]     = 1'b1;
                rd_val[TIOF_ABS_CTRL_BIT]     = abs_q;
                rd_val[TIOF_ON_OFF_BIT]       = on_q;
                rd_val[TIOF_POLARITY_BIT]     = pol_q;
                rd_val[TIOF_SOURCE_LSB +: 3]  = src_q;
                rd_val[TIOF_TRIG_VALUE_BIT]   = raw_lvl;
                rd_val[TIOF_MODE_LSB +: 4]    = mode_q;
                rd_val[TIOF_PARAM_LSB +: 12]  = param_q;
            end
            TIOF_FRAME_INFO_OFF: begin
                rd_val[TIOF_PRESENCE_BIT]      = 1'b1;
                rd_val[TIOF_AVAIL_LSB +: 10]   = AVAIL_ITEMS;
                rd_val[TIOF_VALFMT_BIT]        = ABS_FMT;
            end
            TIOF_PIN_STATUS_OFF: begin
                rd_val[0] = raw_lvl;
                rd_val[1] = act_lvl;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= TIOF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? TIOF_RESP_OKAY : TIOF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Control outputs
    assign supply_en   = supply_q;
    assign trig_enable = on_q;
    assign trig_source = src_q;
    assign trig_mode   = mode_q;
    assign trig_param  = param_q;
    assign trig_abs    = abs_q;
    assign trig_active = act_lvl;

    // Checks
    sequence s_wr_trig;
        do_wr && {awaddr_q[15:2], 2'b00} == TIOF_TRIG_CTRL_OFF;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_both_held;
        aw_q && w_q && !s_axi_bvalid;
    endsequence

    // Reset values and the supply bit
    a_supply_reset: assert property (@(posedge clk) srst |=> !supply_en)
        else $error("supply enable not off after reset");
    a_bus_reset: assert property (@(posedge clk) srst |=> !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus answer pending after reset");
    a_supply_write: assert property (@(posedge clk) disable iff (srst)
        do_wr && {awaddr_q[15:2], 2'b00} == TIOF_SUPPLY_EN_OFF && wstrb_q[0]
        |=> supply_en == $past(wdata_q[0]))
        else $error("supply enable did not follow write");

    // Bus answers: one cycle after the request, write answer gone once taken
    a_write_answer: assert property (@(posedge clk) disable iff (srst)
        s_both_held |=> s_axi_bvalid)
        else $error("write answer missing");
    a_read_answer: assert property (@(posedge clk) disable iff (srst)
        s_rd_take |=> s_axi_rvalid)
        else $error("read answer missing");
    a_answer_drop: assert property (@(posedge clk) disable iff (srst)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer kept after taken");
    a_write_okay: assert property (@(posedge clk) disable iff (srst)
        s_both_held and wr_hit |=> s_axi_bresp == TIOF_RESP_OKAY)
        else $error("mapped write refused");
    a_write_error: assert property (@(posedge clk) disable iff (srst)
        s_both_held and !wr_hit |=> s_axi_bresp == TIOF_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_read_okay: assert property (@(posedge clk) disable iff (srst)
        s_rd_take and rd_hit |=> s_axi_rresp == TIOF_RESP_OKAY)
        else $error("mapped read refused");

    // Read images: presence, reserved zeros, read-only bits
    a_presence_read: assert property (@(posedge clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready && rd_hit && {s_axi_araddr[15:2], 2'b00} != TIOF_PIN_STATUS_OFF
        |=> s_axi_rdata[31])
        else $error("presence bit not set");
    a_supply_reserved: assert property (@(posedge clk) disable iff (srst)
        s_rd_take and {s_axi_araddr[15:2], 2'b00} == TIOF_SUPPLY_EN_OFF
        |=> s_axi_rdata[30:1] == 30'h0000_0000)
        else $error("supply reserved bits set");
    a_trig_reserved: assert property (@(posedge clk) disable iff (srst)
        s_rd_take and {s_axi_araddr[15:2], 2'b00} == TIOF_TRIG_CTRL_OFF
        |=> s_axi_rdata[29:26] == 4'h0 && s_axi_rdata[15:12] == 4'h0)
        else $error("trigger reserved bits set");
    a_unmapped_read: assert property (@(posedge clk) disable iff (srst)
        s_rd_take and !rd_hit |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == TIOF_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_pin_status: assert property (@(posedge clk) disable iff (srst)
        s_rd_take and {s_axi_araddr[15:2], 2'b00} == TIOF_PIN_STATUS_OFF
        |=> s_axi_rdata == {30'h0000_0000, $past(act_lvl), $past(raw_lvl)})
        else $error("pin status read wrong");
    a_value_read: assert property (@(posedge clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready && {s_axi_araddr[15:2], 2'b00} == TIOF_TRIG_CTRL_OFF
        |=> s_axi_rdata[20] == $past(raw_lvl))
        else $error("trigger value bit wrong");
    a_frame_info: assert property (@(posedge clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready && {s_axi_araddr[15:2], 2'b00} == TIOF_FRAME_INFO_OFF
        |=> s_axi_rdata[25:16] == AVAIL_ITEMS && s_axi_rdata[15] == ABS_FMT
        && s_axi_rdata[14:0] == 15'h0000)
        else $error("frame info read wrong");

    // Trigger fields: byte lanes, on/off lock, absolute lock, polarity
    a_onoff_write: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and wstrb_q[3] |=> trig_enable == $past(wdata_q[25]))
        else $error("on/off bit not written");
    a_lane_mask: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and !wstrb_q[3] |=> $stable(trig_enable) && $stable(trig_abs) && $stable(pol_q))
        else $error("top lane changed without strobe");
    a_mode_lane: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and !wstrb_q[2] |=> $stable(trig_mode) && $stable(trig_source))
        else $error("mode lane changed without strobe");
    a_abs_write: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and on_q && wstrb_q[3]
        |=> trig_abs == $past(wdata_q[30]) && pol_q == $past(wdata_q[24]))
        else $error("absolute or polarity not written");
    a_abs_param_hold: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and abs_q |=> $stable(param_q))
        else $error("parameter changed under absolute control");
    a_off_fields_hold: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and !on_q |=> $stable(mode_q) && $stable(src_q) && $stable(pol_q))
        else $error("field changed while trigger off");
    a_off_param_hold: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and !on_q |=> $stable(param_q) && $stable(trig_abs))
        else $error("parameter changed while trigger off");
    a_polarity_out: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> trig_active == (raw_lvl ~^ $past(pol_q)))
        else $error("trigger polarity wrong");
    a_mode_write: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and on_q && wstrb_q[2] |=> trig_mode == $past(wdata_q[19:16])
        && trig_source == $past(wdata_q[23:21]))
        else $error("mode or source not written");
    a_param_write: assert property (@(posedge clk) disable iff (srst)
        s_wr_trig and on_q && !abs_q && wstrb_q[1:0] == 2'h3
        |=> trig_param == $past(wdata_q[11:0]))
        else $error("parameter not written");
endmodule : tiof_regs
`default_nettype wire

/* File: dv/test_tiof_regs.sv */
// Testbench for the trigger, pin-supply and frame-info register bank.
// Assumes: the bank sits alone on an AXI4-Lite master driven from here; pins are driven directly.
`timescale 1ns/1ps
`default_nettype none
module test_tiof_regs;
    import tiof_pkg::*;
    localparam logic [9:0]  AVAIL = 10'h2B5;
    localparam logic        ABSF  = 1'b1;
    localparam logic [31:0] FI    = {1'b1, 5'h00, AVAIL, ABSF, 15'h0000};
    logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, supply_en, trig_enable, trig_abs, trig_active;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, trig_mode;
    logic [1:0]  bresp, rresp;
    logic [7:0]  gpio_in;
    logic [2:0]  trig_source;
    logic [11:0] trig_param;
    int          err_count, checks_done, cyc;

    tiof_regs #(.NPINS(8), .AVAIL_ITEMS(AVAIL), .ABS_FMT(ABSF)) i_tiof_regs (
        .clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_in(gpio_in), .supply_en(supply_en),
        .trig_enable(trig_enable), .trig_source(trig_source), .trig_mode(trig_mode),
        .trig_param(trig_param), .trig_abs(trig_abs), .trig_active(trig_active));

    // Clock and time-zero values
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
        {awaddr, araddr, wdata, wstrb, gpio_in} = '0;
        {err_count, checks_done, cyc} = '0;
    end

    // Trigger register image: presence, abs, on/off, polarity, source, raw, mode, parameter
    function automatic logic [31:0] trg(logic ab, logic on, logic po, logic [2:0] sr, logic rv,
                                        logic [3:0] md, logic [11:0] pm);
        return {1'b1, ab, 4'h0, on, po, sr, rv, md, 4'h0, pm};
    endfunction : trg

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("Error: %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask : check

    // Write one word; address and data offered together, each released once taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ha, hw, hb;
        logic [1:0] r;
        hb = 1'b0;
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
        while (!hb) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r  = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
        check("bresp", 32'(r), 32'(er));
    endtask : wr

    // Read one word and compare data and response
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ha, hr;
        logic [31:0] d;
        logic [1:0] r;
        hr = 1'b0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!hr) begin
            @(negedge clk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            d  = rdata;
            r  = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
        check("rresp", 32'(r), 32'(er));
        check("rdata", d, exp);
    endtask : rd

    task automatic tdone(input string name);
        $display("Test %s done", name);
    endtask : tdone

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(TIOF_SUPPLY_EN_OFF, 32'h80000000, TIOF_RESP_OKAY);
        rd(TIOF_TRIG_CTRL_OFF, trg(0, 0, 0, 0, 0, 0, 0), TIOF_RESP_OKAY);
        rd(TIOF_FRAME_INFO_OFF, FI, TIOF_RESP_OKAY);
        check("supply_en", 32'(supply_en), 32'h0);
        tdone("reset");
        // Supply bit set and cleared, presence stays
        wr(TIOF_SUPPLY_EN_OFF, 32'hFFFFFFFF, 4'hF, TIOF_RESP_OKAY);
        rd(TIOF_SUPPLY_EN_OFF, 32'h80000001, TIOF_RESP_OKAY);
        check("supply_en", 32'(supply_en), 32'h1);
        wr(TIOF_SUPPLY_EN_OFF, 32'h7FFFFFFE, 4'hF, TIOF_RESP_OKAY);
        rd(TIOF_SUPPLY_EN_OFF, 32'h80000000, TIOF_RESP_OKAY);
        check("supply_en", 32'(supply_en), 32'h0);
        tdone("supply");
        // Fields locked while off, then enabled and written
        wr(TIOF_TRIG_CTRL_OFF, trg(1, 0, 1, 5, 1, 9, 12'h123), 4'hF, TIOF_RESP_OKAY);
        rd(TIOF_TRIG_CTRL_OFF, trg(0, 0, 0, 0, 0, 0, 0), TIOF_RESP_OKAY);
        wr(TIOF_TRIG_CTRL_OFF, trg(0, 1, 0, 0, 0, 0, 0), 4'hF, TIOF_RESP_OKAY);
        check("trig_enable", 32'(trig_enable), 32'h1);
        wr(TIOF_TRIG_CTRL_OFF, trg(0, 1, 1, 3, 1, 4'hA, 12'h5A5), 4'hF, TIOF_RESP_OKAY);
        rd(TIOF_TRIG_CTRL_OFF, trg(0, 1, 1, 3, 0, 4'hA, 12'h5A5), TIOF_RESP_OKAY);
        check("trig_source", 32'(trig_source), 32'h3);
        check("trig_param", 32'(trig_param), 32'h5A5);
        tdone("trigger_fields");
        // Parameter frozen while absolute control is set
        wr(TIOF_TRIG_CTRL_OFF, trg(1, 1, 1, 3, 0, 4'hA, 12'h5A5), 4'hF, TIOF_RESP_OKAY);
        wr(TIOF_TRIG_CTRL_OFF, trg(1, 1, 1, 3, 0, 4'hA, 12'h0F0), 4'hF, TIOF_RESP_OKAY);
        rd(TIOF_TRIG_CTRL_OFF, trg(1, 1, 1, 3, 0, 4'hA, 12'h5A5), TIOF_RESP_OKAY);
        check("trig_abs", 32'(trig_abs), 32'h1);
        wr(TIOF_TRIG_CTRL_OFF, trg(0, 1, 1, 3, 0, 4'hA, 12'h5A5), 4'hF, TIOF_RESP_OKAY);
        check("trig_abs", 32'(trig_abs), 32'h0);
        tdone("absolute");
        // Every trigger mode
        for (int m = 0; m < 16; m++) begin
            wr(TIOF_TRIG_CTRL_OFF, trg(0, 1, 1, 3, 0, 4'(m), 12'h5A5), 4'hF, TIOF_RESP_OKAY);
            check("trig_mode", 32'(trig_mode), 32'(m));
        end
        tdone("modes");
        // Raw level and polarity on pin 3
        gpio_in <= 8'h08;
        repeat (4) @(posedge clk);
        check("trig_active", 32'(trig_active), 32'h1);
        rd(TIOF_TRIG_CTRL_OFF, trg(0, 1, 1, 3, 1, 4'hF, 12'h5A5), TIOF_RESP_OKAY);
        rd(TIOF_PIN_STATUS_OFF, 32'h00000003, TIOF_RESP_OKAY);
        wr(TIOF_TRIG_CTRL_OFF, trg(0, 1, 0, 3, 0, 4'hF, 12'h5A5), 4'hF, TIOF_RESP_OKAY);
        repeat (4) @(posedge clk);
        check("trig_active", 32'(trig_active), 32'h0);
        gpio_in <= 8'h00;
        repeat (4) @(posedge clk);
        check("trig_active", 32'(trig_active), 32'h1);
        rd(TIOF_PIN_STATUS_OFF, 32'h00000002, TIOF_RESP_OKAY);
        tdone("polarity");
        // Each source picks its own pin; odd pins are low among high neighbours
        for (int i = 0; i < 8; i++) begin
            gpio_in <= (i % 2 == 0) ? (8'h01 << i) : ~(8'h01 << i);
            wr(TIOF_TRIG_CTRL_OFF, trg(0, 1, 0, 3'(i), 0, 4'hF, 12'h5A5), 4'hF, TIOF_RESP_OKAY);
            repeat (4) @(posedge clk);
            rd(TIOF_TRIG_CTRL_OFF, trg(0, 1, 0, 3'(i), (i % 2 == 0), 4'hF, 12'h5A5), TIOF_RESP_OKAY);
        end
        tdone("sources");
        // Low lanes only: parameter changes, upper fields keep their values
        wr(TIOF_TRIG_CTRL_OFF, trg(1, 0, 1, 0, 0, 0, 12'h321), 4'h3, TIOF_RESP_OKAY);
        rd(TIOF_TRIG_CTRL_OFF, trg(0, 1, 0, 7, 0, 4'hF, 12'h321), TIOF_RESP_OKAY);
        wr(TIOF_TRIG_CTRL_OFF, trg(0, 0, 0, 7, 0, 4'hF, 12'h321), 4'hF, TIOF_RESP_OKAY);
        wr(TIOF_TRIG_CTRL_OFF, trg(0, 0, 1, 2, 0, 4'h3, 12'h0AB), 4'hF, TIOF_RESP_OKAY);
        rd(TIOF_TRIG_CTRL_OFF, trg(0, 0, 0, 7, 0, 4'hF, 12'h321), TIOF_RESP_OKAY);
        check("trig_enable", 32'(trig_enable), 32'h0);
        tdone("lanes_and_off");
        // Capability register ignores writes; unmapped place answers with an error
        wr(TIOF_FRAME_INFO_OFF, 32'hFFFFFFFF, 4'hF, TIOF_RESP_OKAY);
        rd(TIOF_FRAME_INFO_OFF, FI, TIOF_RESP_OKAY);
        wr(16'h0004, 32'hFFFFFFFF, 4'hF, TIOF_RESP_SLVERR);
        rd(16'h0004, 32'h00000000, TIOF_RESP_SLVERR);
        tdone("read_only_and_unmapped");
        // Reset in mid-run turns the supply and trigger fields off again
        wr(TIOF_SUPPLY_EN_OFF, 32'h00000001, 4'h1, TIOF_RESP_OKAY);
        check("supply_en", 32'(supply_en), 32'h1);
        gpio_in <= 8'h00;
        srst    <= 1'b1;
        repeat (2) @(posedge clk);
        srst    <= 1'b0;
        check("supply_en", 32'(supply_en), 32'h0);
        rd(TIOF_SUPPLY_EN_OFF, 32'h80000000, TIOF_RESP_OKAY);
        rd(TIOF_TRIG_CTRL_OFF, trg(0, 0, 0, 0, 0, 0, 0), TIOF_RESP_OKAY);
        check("trig_enable", 32'(trig_enable), 32'h0);
        tdone("mid_run_reset");
        summarize();
    end
endmodule : test_tiof_regs
`default_nettype wire
